// [design/i2crs_consts.vh]
// Constants for the two-wire register access slave
`ifndef I2CRS_CONSTS_VH
`define I2CRS_CONSTS_VH
`define I2CRS_FIXED_ADDR 4'h4
`define I2CRS_REG_ALARM 4'h0
`define I2CRS_REG_MASK 4'h1
`define I2CRS_REG_PEND 4'h2
`define I2CRS_REG_OKMASK 4'h3
`define I2CRS_REG_WDOG 4'h4
`define I2CRS_REG_HIST 4'h5
`define I2CRS_RST_BYTE 8'h00
`define I2CRS_MASK_RW 8'hFE
`define I2CRS_OKMASK_RW 8'h1E
`define I2CRS_WDOG_RW 8'h1F
`define I2CRS_HIST_RW 8'h1F
// Level cause quiet time, 10 us of 50 ns clocks, sized for the rearm counter
`define I2CRS_REARM_CYC 16'h00C8
`endif

// [design/i2crs_pin_sync.v]
// Two-stage synchroniser and edge finder for the bus pins
`timescale 1ns/1ns
module i2crs_pin_sync
(
   input wire clk_in,
   input wire sys_rst_in,
   input wire pin_in,
   output reg level_out,
   output wire rise_out,
   output wire fall_out
);
   reg meta_reg;
   reg prev_reg;
   always @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         meta_reg <= 1'b1;
         level_out <= 1'b1;
         prev_reg <= 1'b1;
      end
      else
      begin
         meta_reg <= pin_in;
         level_out <= meta_reg;
         prev_reg <= level_out;
      end
   end
   assign rise_out = level_out & ~prev_reg;
   assign fall_out = ~level_out & prev_reg;
endmodule

// [design/i2crs_slave.v]
// Two-wire slave giving a host access to sixteen byte registers
// ****************************************
// How it works
// - Slave acknowledges every register address byte
// - Bytes move eight bits, MSB first
// - Matching read address acked, pointed register sent
// - Sixteen registers of eight bits each
// - Access works only in software mode
// - Addresses 00 to 0F, low nibble selects
// - Ack address only when seven bits match
// - Direction bit one reads, zero writes
// - Mask one lets cause raise interrupt
// - Status read clears; levels rearm after 10us
// ****************************************
`timescale 1ns/1ns
`include "i2crs_consts.vh"
module i2crs_slave
(
   input wire clk_in,
   input wire sys_rst_in,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe_out,
   input wire sw_mode_in,
   input wire [2:0] addr_sel_in,
   input wire [7:0] alarm_state_in,
   input wire wdog_timeout_in,
   input wire [7:0] ext_reg_data_in,
   output reg [3:0] ext_reg_addr_out,
   output reg ext_wr_out,
   output reg [7:0] ext_wr_data_out,
   output wire [7:0] mask_out,
   output wire [7:0] okmask_out,
   output wire [7:0] wdog_ctrl_out,
   output wire [7:0] hist_out,
   output wire irq_n_out
);
   // ****************************************
   // Pin sampling
   // ****************************************
   wire scl_lvl;
   wire scl_rise;
   wire scl_fall;
   wire sda_lvl;
   wire sda_rise;
   wire sda_fall;
   i2crs_pin_sync u_scl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(scl_in),
      .level_out(scl_lvl), .rise_out(scl_rise), .fall_out(scl_fall));
   i2crs_pin_sync u_sda (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(sda_in),
      .level_out(sda_lvl), .rise_out(sda_rise), .fall_out(sda_fall));
   wire start_det = sda_fall & scl_lvl;
   wire stop_det = sda_rise & scl_lvl;
   reg sw_meta_reg;
   reg sw_mode_reg;
   always @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         sw_meta_reg <= 1'b0;
         sw_mode_reg <= 1'b0;
      end
      else
      begin
         sw_meta_reg <= sw_mode_in;
         sw_mode_reg <= sw_meta_reg;
      end
   end
   // ****************************************
   // Register file
   // ****************************************
   reg [7:0] mask_reg;
   reg [7:0] okmask_reg;
   reg [7:0] wdog_reg;
   reg [7:0] hist_reg;
   reg [7:0] pend_reg;
   reg [15:0] rearm_reg;
   reg wd_prev_reg;
   assign mask_out = mask_reg;
   assign okmask_out = okmask_reg;
   assign wdog_ctrl_out = wdog_reg;
   assign hist_out = hist_reg;
   assign irq_n_out = ~(|pend_reg);
   function [7:0] rd_mux;
      input [3:0] a;
      input [7:0] alm;
      input [7:0] ext;
      begin
         case (a)
            `I2CRS_REG_ALARM: rd_mux = alm;
            `I2CRS_REG_MASK: rd_mux = mask_reg;
            `I2CRS_REG_PEND: rd_mux = pend_reg;
            `I2CRS_REG_OKMASK: rd_mux = okmask_reg;
            `I2CRS_REG_WDOG: rd_mux = wdog_reg;
            `I2CRS_REG_HIST: rd_mux = hist_reg;
            default: rd_mux = ext;
         endcase
      end
   endfunction
   // ****************************************
   // Protocol engine
   // ****************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_DEVADR = 3'h1;
   localparam ST_ACK = 3'h2;
   localparam ST_REGADR = 3'h3;
   localparam ST_WDATA = 3'h4;
   localparam ST_RDATA = 3'h5;
   localparam ST_MACK = 3'h6;
   reg [2:0] state_reg;
   reg [2:0] after_ack_reg;
   reg [3:0] bit_cnt_reg;
   reg [7:0] shift_reg;
   reg [7:0] ptr_reg;
   reg sda_drv_reg;
   reg read_fetch;
   wire [6:0] my_addr = {`I2CRS_FIXED_ADDR, addr_sel_in};
   wire byte_done = scl_rise & (bit_cnt_reg == 4'h7);
   wire active = sw_mode_reg;
   wire [7:0] rd_byte = rd_mux(ptr_reg[3:0], alarm_state_in, ext_reg_data_in);
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_drv_reg;
   // Fetch only on the fall that loads the byte, so a clear never hides what is sent
   always @*
   begin
      read_fetch = 1'b0;
      if (state_reg == ST_ACK && scl_fall && sda_drv_reg && after_ack_reg == ST_RDATA)
         read_fetch = 1'b1;
      if (state_reg == ST_MACK && scl_fall && !sda_lvl)
         read_fetch = 1'b1;
   end
   // Level causes for the pending flags, bit 0 is watchdog event
   // mask gates causes 7 to 1, watchdog bit 0 is never masked
   wire wd_evt = wdog_timeout_in & ~wd_prev_reg;
   wire [7:0] causes = {alarm_state_in[7:1], wd_evt} & {mask_reg[7:1], 1'b1};
   wire rearmed = (rearm_reg == 16'h0000);
   wire pend_rd = read_fetch & (ptr_reg == {4'h0, `I2CRS_REG_PEND});
   always @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_reg <= ST_IDLE;
         after_ack_reg <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         sda_drv_reg <= 1'b0;
         mask_reg <= `I2CRS_RST_BYTE;
         okmask_reg <= `I2CRS_RST_BYTE;
         wdog_reg <= `I2CRS_RST_BYTE;
         hist_reg <= `I2CRS_RST_BYTE;
         pend_reg <= 8'h00;
         rearm_reg <= 16'h0000;
         wd_prev_reg <= 1'b0;
         ext_reg_addr_out <= 4'h0;
         ext_wr_out <= 1'b0;
         ext_wr_data_out <= 8'h00;
      end
      else
      begin
         ext_wr_out <= 1'b0;
         wd_prev_reg <= wdog_timeout_in;
         if (pend_rd)
         begin
            pend_reg <= {7'h00, wd_evt};
            rearm_reg <= `I2CRS_REARM_CYC;
         end
         else
         begin
            if (!rearmed)
               rearm_reg <= rearm_reg - 16'h0001;
            pend_reg <= pend_reg | (rearmed ? causes : {7'h00, wd_evt});
         end
         if (!active || stop_det)
         begin
            state_reg <= ST_IDLE;
            sda_drv_reg <= 1'b0;
         end
         else if (start_det)
         begin
            state_reg <= ST_DEVADR;
            bit_cnt_reg <= 4'h0;
            sda_drv_reg <= 1'b0;
         end
         else
         begin
            case (state_reg)
               ST_IDLE:
                  sda_drv_reg <= 1'b0;
               ST_DEVADR, ST_REGADR, ST_WDATA:
               begin
                  if (scl_rise)
                  begin
                     shift_reg <= {shift_reg[6:0], sda_lvl};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
                  if (byte_done)
                  begin
                     bit_cnt_reg <= 4'h0;
                     state_reg <= ST_ACK;
                     if (state_reg == ST_DEVADR)
                     begin
                        if (shift_reg[6:0] != my_addr)
                           state_reg <= ST_IDLE;
                        after_ack_reg <= sda_lvl ? ST_RDATA : ST_REGADR;
                     end
                     else if (state_reg == ST_REGADR)
                     begin
                        ptr_reg <= {shift_reg[6:0], sda_lvl};
                        after_ack_reg <= ST_WDATA;
                     end
                     else
                     begin
                        ext_wr_data_out <= {shift_reg[6:0], sda_lvl};
                        after_ack_reg <= ST_WDATA;
                        if (ptr_reg[7:4] == 4'h0)
                        begin
                           case (ptr_reg[3:0])
                              `I2CRS_REG_ALARM, `I2CRS_REG_PEND: ;
                              `I2CRS_REG_MASK: mask_reg <= {shift_reg[6:0], sda_lvl} & `I2CRS_MASK_RW;
                              `I2CRS_REG_OKMASK: okmask_reg <= {shift_reg[6:0], sda_lvl} & `I2CRS_OKMASK_RW;
                              `I2CRS_REG_WDOG: wdog_reg <= {shift_reg[6:0], sda_lvl} & `I2CRS_WDOG_RW;
                              `I2CRS_REG_HIST: hist_reg <= {shift_reg[6:0], sda_lvl} & `I2CRS_HIST_RW;
                              default:
                              begin
                                 ext_reg_addr_out <= ptr_reg[3:0];
                                 ext_wr_out <= 1'b1;
                              end
                           endcase
                        end
                     end
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall && !sda_drv_reg)
                     sda_drv_reg <= 1'b1;
                  else if (scl_fall && sda_drv_reg)
                  begin
                     sda_drv_reg <= 1'b0;
                     state_reg <= after_ack_reg;
                     if (after_ack_reg == ST_RDATA)
                     begin
                        shift_reg <= rd_byte;
                        sda_drv_reg <= ~rd_byte[7];
                     end
                  end
               end
               ST_RDATA:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     sda_drv_reg <= ~shift_reg[6];
                     if (bit_cnt_reg == 4'h7)
                     begin
                        sda_drv_reg <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_MACK;
                     end
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise)
                     state_reg <= sda_lvl ? ST_IDLE : ST_MACK;
                  if (scl_fall && state_reg == ST_MACK && !sda_lvl)
                  begin
                     shift_reg <= rd_byte;
                     sda_drv_reg <= ~rd_byte[7];
                     state_reg <= ST_RDATA;
                  end
               end
               default:
                  state_reg <= ST_IDLE;
            endcase
         end
      end
   end
endmodule

// [sim/i2crs_host_model.sv]
// Bus master model for the slave's two-wire pins
`timescale 1ns/1ns
module i2crs_host_model
(
   input wire sda_in,
   output reg scl_out = 1'b1,
   output reg sda_low_out = 1'b0
);
   // one bit per 400 ns clock
   task bit1(input b, output r);
      begin
         sda_low_out = !b;
         #100 scl_out = 1'b1;
         #100 r = sda_in;
         #100 scl_out = 1'b0;
         #100;
      end
   endtask
   // start or repeated start, stop leaves clock still
   task cond(input p);
      begin
         sda_low_out = p;
         #100 scl_out = 1'b1;
         #100 sda_low_out = !p;
         #100 scl_out = p;
         #100;
      end
   endtask
   // byte MSB first, ninth bit read back
   task xb(input [7:0] b, output [7:0] r, output k);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            bit1(b[i], r[i]);
         bit1(1'b1, k);
         k = !k;
      end
   endtask
   // pointer write, then one data byte or a read
   task xfer(input rd, input [6:0] dev, input [7:0] a, input [7:0] d, output [7:0] q, output [2:0] k);
      reg n;
      begin
         cond(1'b0);
         xb({dev, 1'b0}, q, k[2]);
         xb(a, q, k[1]);
         if (rd)
         begin
            cond(1'b0);
            xb({dev, 1'b1}, q, k[0]);
            xb(8'hFF, q, n);
         end
         else
            xb(d, q, k[0]);
         cond(1'b1);
      end
   endtask
endmodule

// [sim/i2crs_slave_monitor.sv]
// Concurrent checks on the two-wire register slave ports
`timescale 1ns/1ns
module i2crs_slave_monitor
(
   input wire clk_in,
   input wire sys_rst_in,
   input wire scl_in,
   input wire sw_mode_in,
   input wire wdog_timeout_in,
   input wire sda_oe_out,
   input wire ext_wr_out,
   input wire [3:0] ext_reg_addr_out,
   input wire [7:0] mask_out,
   input wire [7:0] okmask_out,
   input wire [7:0] wdog_ctrl_out,
   input wire irq_n_out
);
   // ****************
   // Port checks
   // ****************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   a_ack_scl_low: assert property ($rose(sda_oe_out) |-> !scl_in) else $error("drive began in clock high");
   a_data_stable: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out)) else $error("data moved");
   a_mode_idle: assert property (!sw_mode_in [*5] |-> !sda_oe_out) else $error("drive outside mode");
   a_wr_pulse: assert property (ext_wr_out |=> !ext_wr_out) else $error("long write strobe");
   a_wr_ext_only: assert property (ext_wr_out |-> ext_reg_addr_out >= 4'h6) else $error("bad strobe");
   a_reserved_zero: assert property (!mask_out[0] && !okmask_out[0] && okmask_out[7:5] == 3'h0
      && wdog_ctrl_out[7:5] == 3'h0) else $error("reserved bit set");
   a_regs_rx: assert property (!$stable({mask_out, okmask_out, wdog_ctrl_out}) |-> !sda_oe_out)
      else $error("update while sending");
   a_wdog_irq: assert property ($rose(wdog_timeout_in) |-> ##[1:8] !irq_n_out) else $error("no interrupt");
   cover property (ext_wr_out);
   cover property ($fell(irq_n_out));
   cover property ($rose(sda_oe_out) && sw_mode_in);
endmodule
bind i2crs_slave i2crs_slave_monitor i2crs_slave_monitor_i (.clk_in, .sys_rst_in, .scl_in, .sw_mode_in,
   .wdog_timeout_in, .sda_oe_out, .ext_wr_out, .ext_reg_addr_out, .mask_out, .okmask_out, .wdog_ctrl_out, .irq_n_out);

// [sim/i2c_register_access_slave_tb.sv]
// Self-checking bench for the two-wire register access slave
`timescale 1ns/1ns
module i2c_register_access_slave_tb;
   reg clk_in = 1'b0, rst = 1'b1, mode = 1'b1, wdog = 1'b0;
   reg [2:0] sel = 3'h5;
   reg [7:0] alarm = 8'h00, ext_d = 8'h00, wseen = 8'h00, got;
   reg [3:0] wadr = 4'h0;
   wire [3:0] wa;
   wire [7:0] hist;
   reg [2:0] k;
   wire sda_o, oe, scl, low, wr, irq_n;
   wire [7:0] wd, mask, okm, wdc;
   // Open-drain line with pull-up
   wire sda = !((oe && !sda_o) || low);
   wire [6:0] dev = {4'h4, sel};
   integer err_total = 0, comparisons = 0, cyc = 0, i;
   i2crs_slave i2crs_slave_i (.clk_in(clk_in), .sys_rst_in(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
      .sda_oe_out(oe), .sw_mode_in(mode), .addr_sel_in(sel), .alarm_state_in(alarm), .wdog_timeout_in(wdog),
      .ext_reg_data_in(ext_d), .ext_reg_addr_out(wa), .ext_wr_out(wr), .ext_wr_data_out(wd), .mask_out(mask),
      .okmask_out(okm), .wdog_ctrl_out(wdc), .hist_out(hist), .irq_n_out(irq_n));
   i2crs_host_model h (.sda_in(sda), .scl_out(scl), .sda_low_out(low));
   always #25 clk_in = !clk_in;
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (wr === 1'b1)
      begin
         wseen <= wd;
         wadr <= wa;
      end
      if (cyc == 20000)
         report_and_stop;
   end
   task chk(input [7:0] g, input [7:0] e);
      begin
         comparisons = comparisons + 1;
         if (g !== e)
         begin
            err_total = err_total + 1;
            $display("ERROR %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   // Frames start 7 ns after an edge so pins never move on one
   task io(input rd, input [6:0] dv, input [7:0] a, input [7:0] d, input [2:0] ke);
      begin
         @(posedge clk_in);
         #7;
         h.xfer(rd, dv, a, d, got, k);
         chk({5'h00, k}, {5'h00, ke});
         if (rd)
            chk(got, d);
      end
   endtask
   task report_and_stop;
      begin
         if (cyc >= 20000)
         begin
            err_total = err_total + 1;
            $display("ERROR %0t timeout", $time);
         end
         $display("mismatches %0d comparisons %0d", err_total, comparisons);
         if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial
   begin
      repeat (12) @(posedge clk_in);
      rst <= 1'b0;
      for (i = 0; i < 6; i = i + 1)
         io(1'b1, dev, i[7:0], 8'h00, 3'h7);
      @(posedge clk_in) alarm <= 8'hA5;
      io(1'b1, dev, 8'h00, 8'hA5, 3'h7);
      io(1'b0, dev, 8'h00, 8'h0F, 3'h7);
      io(1'b1, dev, 8'h00, 8'hA5, 3'h7);
      io(1'b1, dev, 8'h02, 8'h00, 3'h7);
      @(posedge clk_in) alarm <= 8'h00;
      io(1'b0, dev, 8'h01, 8'hFF, 3'h7);
      io(1'b0, dev, 8'h03, 8'hFF, 3'h7);
      io(1'b0, dev, 8'h04, 8'hE8, 3'h7);
      io(1'b0, dev, 8'h0A, 8'h5A, 3'h7);
      io(1'b0, dev, 8'h11, 8'h77, 3'h7);
      io(1'b1, dev, 8'h01, 8'hFE, 3'h7);
      chk(wseen, 8'h5A);
      chk(okm, 8'h1E);
      chk(wdc, 8'h08);
      chk({4'h0, wadr}, 8'h0A);
      io(1'b0, dev, 8'h05, 8'hFF, 3'h7);
      chk(hist, 8'h1F);
      io(1'b1, dev, 8'h05, 8'h1F, 3'h7);
      @(posedge clk_in) ext_d <= 8'hC3;
      io(1'b1, dev, 8'h0F, 8'hC3, 3'h7);
      $display("register access test done");
      @(posedge clk_in) wdog <= 1'b1;
      repeat (8) @(negedge clk_in);
      chk({7'h00, irq_n}, 8'h00);
      io(1'b1, dev, 8'h02, 8'h01, 3'h7);
      @(posedge clk_in) alarm <= 8'h80;
      // The last status read started a quiet time, so wait it out before the level cause shows
      repeat (200) @(negedge clk_in);
      chk({7'h00, irq_n}, 8'h00);
      io(1'b1, dev, 8'h02, 8'h80, 3'h7);
      chk({7'h00, irq_n}, 8'h01);
      // Level cause stays active, so it must come back after the quiet time
      repeat (220) @(negedge clk_in);
      chk({7'h00, irq_n}, 8'h00);
      $display("interrupt test done");
      io(1'b1, {4'h4, ~sel}, 8'h01, 8'hFF, 3'h0);
      @(posedge clk_in) mode <= 1'b0;
      io(1'b0, dev, 8'h01, 8'h00, 3'h0);
      chk(mask, 8'hFE);
      $display("refusal test done");
      @(posedge clk_in) rst <= 1'b1;
      @(posedge clk_in) rst <= 1'b0;
      @(negedge clk_in);
      chk(mask, 8'h00);
      chk({7'h00, oe}, 8'h00);
      $display("reset test done");
      report_and_stop;
   end
endmodule
